// [host_link_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Host side of the serial programming link
// ------------------------------------------------------------
module host_link_model (
  // Clock
  input  wire logic clk_sys_i,
  // Serial link
  output var logic  ser_clk_o,
  output var logic  ser_data_o,
  output var logic  ser_latch_o
);
  localparam int HALF = 10; // 80 ns link period at 4 ns

  // Idle: link clock parked low, latch high
  initial begin
    ser_clk_o   = 1'b0;
    ser_data_o  = 1'b0;
    ser_latch_o = 1'b1;
  end

  // One word, first bit the top one, taken on rising link clock
  task automatic send(input logic [31:0] word);
    @(posedge clk_sys_i);
    ser_latch_o <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      repeat (HALF) @(posedge clk_sys_i);
      ser_data_o <= word[i];
      ser_clk_o  <= 1'b0;
      repeat (HALF) @(posedge clk_sys_i);
      ser_clk_o <= 1'b1;
    end
    repeat (HALF) @(posedge clk_sys_i);
    ser_clk_o <= 1'b0;
    repeat (HALF) @(posedge clk_sys_i);
    ser_latch_o <= 1'b1;
    ser_data_o  <= ~word[0]; // Released line must not keep the last bit
    repeat (HALF) @(posedge clk_sys_i);
  endtask : send
endmodule : host_link_model
`default_nettype wire

// [lock_detect.sv]
`timescale 1ns/1ns
`default_nettype none
module lock_detect
  import zd_seq_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  // Phase comparison
  input  wire logic clear_i,
  input  wire logic ref_edge_i,
  input  wire logic fb_edge_i,
  // Result
  output logic      locked_o
);

  logic [7:0] err_q;
  logic       busy_q;
  logic [2:0] good_q;

  // ------------------------------------------------------------
  // Phase error measured from first edge to the other
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      err_q  <= 8'h00;
      busy_q <= 1'b0;
      good_q <= 3'h0;
      locked_o <= 1'b0;
    end else if (clear_i) begin
      err_q  <= 8'h00;
      busy_q <= 1'b0;
      good_q <= 3'h0;
      locked_o <= 1'b0;
    end else if (ref_edge_i && fb_edge_i) begin
      // Coincident edges: zero error counts as a good cycle
      busy_q <= 1'b0;
      if (good_q == 3'(LOCK_CYCLES - 1)) begin
        locked_o <= 1'b1;
      end else begin
        good_q <= good_q + 3'h1;
      end
    end else if (ref_edge_i || fb_edge_i) begin
      if (busy_q) begin
        busy_q <= 1'b0;
        // A closing edge as late as the wide window must drop lock too,
        // otherwise an error of exactly one window plus a cycle slips by
        if (locked_o) begin
          if (err_q >= 8'(UNLOCK_CYC)) begin
            locked_o <= 1'b0;
            good_q   <= 3'h0;
          end
        end else if (err_q < 8'(LOCK_WIN_CYC)) begin
          if (good_q == 3'(LOCK_CYCLES - 1)) begin
            locked_o <= 1'b1;
          end else begin
            good_q <= good_q + 3'h1;
          end
        end else begin
          good_q <= 3'h0;
        end
      end else begin
        busy_q <= 1'b1;
        err_q  <= 8'h00;
      end
    end else if (busy_q) begin
      // Error longer than the wider window drops lock
      if (err_q != 8'hFF) begin
        err_q <= err_q + 8'h01;
      end
      if (locked_o && err_q >= 8'(UNLOCK_CYC)) begin
        locked_o <= 1'b0;
        good_q   <= 3'h0;
      end
      if (!locked_o && err_q >= 8'(LOCK_WIN_CYC)) begin
        good_q <= 3'h0;
      end
    end
  end

  a_unlock_wide: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (locked_o && busy_q && err_q >= 8'(UNLOCK_CYC) && !(ref_edge_i && fb_edge_i)
     && !clear_i) |=> !locked_o)
    else $error("lock held past unlock window");

endmodule : lock_detect
`default_nettype wire

// [zd_seq_pkg.sv]
package zd_seq_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS   = 32;
  localparam int ADDR_BITS   = 4;
  localparam int ADDR_LSB    = 0;
  localparam logic [3:0] REG_ZERO     = 4'h0;
  localparam logic [3:0] REG_FIVE     = 4'h5;
  localparam logic [3:0] REG_SIX      = 4'h6;
  localparam logic [3:0] REG_FOURTEEN = 4'hE;
  localparam logic [3:0] REG_FIFTEEN  = 4'hF;

  // Register zero fields
  localparam int R0_RESET_BIT    = 31;
  localparam int R0_CALREP_BIT   = 28;
  localparam int R0_ZDELAY_BIT   = 27;
  localparam int R0_FBSEL_LSB    = 25;
  // Channel register fields
  localparam int CH_EN_BIT       = 16;
  localparam int CH_DIV_LSB      = 8;
  // Register fourteen fields
  localparam int R14_GLOBAL_BIT  = 27;
  localparam int R14_LDSEL_LSB   = 20;
  localparam int R14_RDIV_LSB    = 8;
  // Register fifteen fields
  localparam int R15_GAIN_LSB    = 26;
  localparam int R15_POSTDIV_LSB = 22;
  localparam int R15_NDIV_LSB    = 4;

  // Reset values of all shadow registers
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // Feedback source encodings
  localparam logic [1:0] FB_CH_FIVE = 2'h0;
  localparam logic [1:0] FB_EXT     = 2'h1;
  localparam logic [1:0] FB_CH_SIX  = 2'h2;

  // Lock pin function select values
  localparam logic [3:0] LD_SEL_HIGH = 4'h3;
  localparam logic [3:0] LD_SEL_LOW  = 4'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 4;
  localparam int LOCK_WINDOW_NS  = 10;
  localparam int UNLOCK_NS       = 20;
  localparam int LOCK_CYCLES     = 5;
  localparam int LOCK_WIN_CYC    = LOCK_WINDOW_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_CYC      = UNLOCK_NS / CLK_PERIOD_NS;
  localparam int CAL_TIME_US     = 2000;
  localparam int CAL_CYC_DEF     = CAL_TIME_US * 1000 / CLK_PERIOD_NS;

  // Decoded configuration that steers the loop
  typedef struct packed {
    logic        calib_report;
    logic        zero_delay;
    logic [1:0]  feedback_sel;
    logic        all_outputs_en;
    logic [3:0]  lock_sel;
    logic [11:0] ref_div;
    logic [2:0]  post_div;
    logic [17:0] fb_div;
  } loop_cfg_t;

endpackage : zd_seq_pkg

// [zero_delay_program_sequencer.sv]
`timescale 1ns/1ns
`default_nettype none
module zero_delay_program_sequencer
  import zd_seq_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_CYC_DEF
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // Serial programming link
  input  wire logic        ser_clk_i,
  input  wire logic        ser_data_i,
  input  wire logic        ser_latch_i,
  // Loop edges and output control
  input  wire logic        ref_edge_i,
  input  wire logic        channel_five_edge_i,
  input  wire logic        channel_six_edge_i,
  input  wire logic        ext_fb_edge_i,
  input  wire logic        global_output_enable_pin_i,
  // Status and decoded settings
  output logic             lock_indicator_pin_o,
  output logic             calibrating_o,
  output loop_cfg_t        loop_cfg_o,
  output logic [17:0]      fb_divide_o,
  output logic [6:0]       channel_output_enable_o,
  output logic [6:0]       channel_gated_enable_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       ser_clk_prev_q;
  logic       ser_latch_prev_q;

  // Two flops before any logic looks at the link pins
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_q <= 3'h4;
      sync2_q <= 3'h4;
      ser_clk_prev_q   <= 1'b0;
      ser_latch_prev_q <= 1'b1;
    end else begin
      sync1_q <= {ser_latch_i, ser_clk_i, ser_data_i};
      sync2_q <= sync1_q;
      ser_clk_prev_q   <= sync2_q[1];
      ser_latch_prev_q <= sync2_q[2];
    end
  end

  logic clk_rise;
  logic latch_rise;
  assign clk_rise   = sync2_q[1] && !ser_clk_prev_q;
  assign latch_rise = sync2_q[2] && !ser_latch_prev_q;

  // ----------------------------------------------------------------
  // Shift register and word latch
  // ----------------------------------------------------------------
  logic [31:0] shift_q;

  // Bits enter MSB first while the latch line is low
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      shift_q <= RESET_WORD;
    end else if (clk_rise && !sync2_q[2]) begin
      shift_q <= {shift_q[30:0], sync2_q[0]};
    end
  end

  logic [3:0] waddr;
  logic       wstrobe;
  logic       soft_reset;
  assign waddr      = shift_q[ADDR_LSB +: ADDR_BITS];
  assign wstrobe    = latch_rise;
  assign soft_reset = wstrobe && waddr == REG_ZERO && shift_q[R0_RESET_BIT];

  // Shadow storage: 16 words addressed by the low address nibble
  logic [31:0] regs_q [16];

  // Reset word restores every register and drops the rest of itself
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= RESET_WORD;
      end
    end else if (soft_reset) begin
      for (int i = 0; i < 16; i++) begin
        regs_q[i] <= RESET_WORD;
      end
    end else if (wstrobe) begin
      regs_q[waddr] <= shift_q;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  loop_cfg_t cfg;
  always_comb begin
    cfg.calib_report   = regs_q[REG_ZERO][R0_CALREP_BIT];
    cfg.zero_delay     = regs_q[REG_ZERO][R0_ZDELAY_BIT];
    cfg.feedback_sel   = regs_q[REG_ZERO][R0_FBSEL_LSB +: 2];
    cfg.all_outputs_en = regs_q[REG_FOURTEEN][R14_GLOBAL_BIT];
    cfg.lock_sel       = regs_q[REG_FOURTEEN][R14_LDSEL_LSB +: 4];
    cfg.ref_div        = regs_q[REG_FOURTEEN][R14_RDIV_LSB +: 12];
    cfg.post_div       = regs_q[REG_FIFTEEN][R15_POSTDIV_LSB +: 3];
    cfg.fb_div         = regs_q[REG_FIFTEEN][R15_NDIV_LSB +: 18];
  end

  // Channel enables; output gating follows the pin with no clocking
  // so a rising pin may clip a runt pulse at the output.
  always_comb begin
    for (int c = 0; c < 7; c++) begin
      channel_output_enable_o[c] = regs_q[c][CH_EN_BIT];
      channel_gated_enable_o[c]  = regs_q[c][CH_EN_BIT] && cfg.all_outputs_en
                                   && global_output_enable_pin_i;
    end
  end

  // Selected feedback channel divide value
  logic [7:0] fb_ch_div;
  logic       fb_edge;
  always_comb begin
    unique case (cfg.feedback_sel)
      FB_CH_FIVE: begin
        fb_ch_div = regs_q[REG_FIVE][CH_DIV_LSB +: 8];
        fb_edge   = channel_five_edge_i;
      end
      FB_CH_SIX: begin
        fb_ch_div = regs_q[REG_SIX][CH_DIV_LSB +: 8];
        fb_edge   = channel_six_edge_i;
      end
      default: begin
        fb_ch_div = 8'h01;
        fb_edge   = ext_fb_edge_i;
      end
    endcase
  end

  // Feedback divide composition by mode
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fb_divide_o <= 18'h00000;
    end else if (cfg.zero_delay) begin
      fb_divide_o <= 18'(cfg.post_div * fb_ch_div * cfg.fb_div);
    end else begin
      fb_divide_o <= 18'(cfg.fb_div * cfg.post_div);
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      loop_cfg_o <= '0;
    end else begin
      loop_cfg_o <= cfg;
    end
  end

  // ----------------------------------------------------------------
  // Frequency calibration timer
  // ----------------------------------------------------------------
  logic [31:0] cal_cnt_q;
  logic        cal_done_q;
  logic        r15_write;
  assign r15_write = wstrobe && !soft_reset && waddr == REG_FIFTEEN;

  // A fresh register fifteen outside zero-delay restarts calibration
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cal_cnt_q     <= 32'h0000_0000;
      calibrating_o <= 1'b0;
      cal_done_q    <= 1'b0;
    end else if (soft_reset) begin
      cal_cnt_q     <= 32'h0000_0000;
      calibrating_o <= 1'b0;
      cal_done_q    <= 1'b0;
    end else if (r15_write && !cfg.zero_delay) begin
      cal_cnt_q     <= 32'(CAL_CYCLES - 1);
      calibrating_o <= 1'b1;
      cal_done_q    <= 1'b0;
    end else if (calibrating_o) begin
      if (cal_cnt_q == 32'h0000_0000) begin
        calibrating_o <= 1'b0;
        cal_done_q    <= 1'b1;
      end else begin
        cal_cnt_q <= cal_cnt_q - 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Digital lock detect
  // ----------------------------------------------------------------
  logic locked;
  lock_detect u_lock (
    .clk_sys_i  (clk_sys_i),
    .reset_i    (reset_i),
    .clear_i    (r15_write || soft_reset || calibrating_o),
    .ref_edge_i (ref_edge_i),
    .fb_edge_i  (fb_edge),
    .locked_o   (locked)
  );

  // ----------------------------------------------------------------
  // Lock pin function
  // ----------------------------------------------------------------
  logic sel_ld;
  logic show_cal;
  logic status;
  assign sel_ld   = cfg.lock_sel == LD_SEL_HIGH || cfg.lock_sel == LD_SEL_LOW;
  assign show_cal = cfg.calib_report && !cfg.zero_delay && sel_ld;
  assign status   = show_cal ? cal_done_q : locked;

  // Select 3 is active high, select 4 inverts; other codes hold low
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      lock_indicator_pin_o <= 1'b0;
    end else if (cfg.lock_sel == LD_SEL_HIGH) begin
      lock_indicator_pin_o <= status;
    end else if (cfg.lock_sel == LD_SEL_LOW) begin
      lock_indicator_pin_o <= !status;
    end else begin
      lock_indicator_pin_o <= 1'b0;
    end
  end

  a_cal_start: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r15_write && !cfg.zero_delay) |=> calibrating_o && !cal_done_q)
    else $error("calibration did not start");
  a_zd_no_cal: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r15_write && cfg.zero_delay && !calibrating_o) |=> !calibrating_o)
    else $error("calibration started in zero-delay mode");
  a_reset_word: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    soft_reset |=> regs_q[REG_ZERO] == RESET_WORD && regs_q[REG_FIFTEEN] == RESET_WORD)
    else $error("reset word did not clear registers");
  a_cal_report: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (show_cal && cfg.lock_sel == LD_SEL_HIGH) |=> lock_indicator_pin_o == $past(cal_done_q))
    else $error("lock pin not showing calibration done");
  a_ld_high: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (cfg.zero_delay && cfg.lock_sel == LD_SEL_HIGH) |=> lock_indicator_pin_o == $past(locked))
    else $error("active high lock indication wrong");
  a_ld_low: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (cfg.zero_delay && cfg.lock_sel == LD_SEL_LOW) |=> lock_indicator_pin_o != $past(locked))
    else $error("active low lock indication wrong");
  a_fb_select: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    cfg.feedback_sel == FB_CH_SIX |-> fb_ch_div == regs_q[REG_SIX][CH_DIV_LSB +: 8])
    else $error("feedback channel six not selected");
  a_shift_in: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (clk_rise && !sync2_q[2]) |=> shift_q[0] == $past(sync2_q[0]))
    else $error("serial bit not shifted in");
  a_div_plain: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!cfg.zero_delay ##1 !cfg.zero_delay && $stable(cfg.fb_div) && $stable(cfg.post_div))
    |-> fb_divide_o == 18'(cfg.fb_div * cfg.post_div))
    else $error("plain feedback divide wrong");
  a_gate_async: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !global_output_enable_pin_i |-> channel_gated_enable_o == 7'h00)
    else $error("outputs not gated by enable pin");

endmodule : zero_delay_program_sequencer
`default_nettype wire

// [zero_delay_program_sequencer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module zero_delay_program_sequencer_tb
  import zd_seq_pkg::*;
();
  // ----------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------
  localparam int CAL      = 20;
  localparam int WATCH_NS = 240000; // Twice the expected run length
  logic        clk_sys  = 1'b0;
  logic        reset    = 1'b1;
  logic        ser_clk;
  logic        ser_data;
  logic        ser_latch;
  logic        ref_edge = 1'b0;
  logic        ch5_edge = 1'b0;
  logic        ch6_edge = 1'b0;
  logic        ext_edge = 1'b0;
  logic        global_output_enable_pin      = 1'b0;
  logic        edge_on  = 1'b0;
  logic [1:0]  fsel     = 2'h0;
  logic [1:0]  fs;
  logic [3:0]  lsel;
  logic [16:0] lf       = 17'h1809E;
  logic [31:0] w;
  logic [31:0] m [16];
  int          fofs     = 0;
  int          ph       = 0;
  int          err_count = 0;
  int          cmp_count = 0;
  logic        lock_pin;
  logic        calibrating;
  loop_cfg_t   loop_cfg;
  logic [17:0] fb_divide;
  logic [6:0]  ch_en;
  logic [6:0]  ch_gated;

  // Free-running system clock
  always #2 clk_sys = ~clk_sys;

  zero_delay_program_sequencer #(.CAL_CYCLES(CAL)) u_zero_delay_program_sequencer (
    .clk_sys_i                  (clk_sys),
    .reset_i                    (reset),
    .ser_clk_i                  (ser_clk),
    .ser_data_i                 (ser_data),
    .ser_latch_i                (ser_latch),
    .ref_edge_i                 (ref_edge),
    .channel_five_edge_i        (ch5_edge),
    .channel_six_edge_i         (ch6_edge),
    .ext_fb_edge_i              (ext_edge),
    .global_output_enable_pin_i (global_output_enable_pin),
    .lock_indicator_pin_o       (lock_pin),
    .calibrating_o              (calibrating),
    .loop_cfg_o                 (loop_cfg),
    .fb_divide_o                (fb_divide),
    .channel_output_enable_o    (ch_en),
    .channel_gated_enable_o     (ch_gated)
  );

  host_link_model u_host_link_model (
    .clk_sys_i   (clk_sys),
    .ser_clk_o   (ser_clk),
    .ser_data_o  (ser_data),
    .ser_latch_o (ser_latch)
  );

  // Phase comparator edges; unselected feedback inputs sit half a period off
  always @(posedge clk_sys) begin
    ph       <= (ph == 15) ? 0 : ph + 1;
    ref_edge <= edge_on && (ph == 0);
    ch5_edge <= edge_on && (ph == ((fsel == FB_CH_FIVE) ? fofs : 8));
    ch6_edge <= edge_on && (ph == ((fsel == FB_CH_SIX) ? fofs : 8));
    ext_edge <= edge_on && (ph == ((fsel == FB_EXT) ? fofs : 8));
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr

  task automatic rnd(output logic [31:0] v);
    lf = lfsr(lf);
    v[15:0] = lf[15:0];
    lf = lfsr(lf);
    v[31:16] = lf[15:0];
  endtask : rnd

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk_val

  // Send one word and mirror it into the register model
  task automatic send_w(input logic [31:0] word);
    u_host_link_model.send(word);
    if (word[3:0] == REG_ZERO && word[R0_RESET_BIT]) begin
      for (int i = 0; i < 16; i++) m[i] = RESET_WORD;
    end else begin
      m[word[3:0]] = word;
    end
  endtask : send_w

  // Compare every decoded output with the model
  task automatic check_all(input string what);
    loop_cfg_t  c;
    logic [6:0] en;
    logic [7:0] cd;
    int         d;
    c = {m[0][28], m[0][27], m[0][26:25], m[14][27], m[14][23:20], m[14][19:8],
         m[15][24:22], m[15][21:4]};
    for (int i = 0; i < 7; i++) en[i] = m[i][CH_EN_BIT];
    cd = (c.feedback_sel == FB_CH_FIVE) ? m[5][15:8] :
         (c.feedback_sel == FB_CH_SIX) ? m[6][15:8] : 8'h01;
    d = c.post_div * c.fb_div * (c.zero_delay ? cd : 8'h01);
    chk_val(48'(loop_cfg), 48'(c), what);
    chk_val(48'(fb_divide), 48'(d[17:0]), what);
    chk_val(48'(ch_en), 48'(en), what);
    chk_val(48'(ch_gated), 48'(en & {7{c.all_outputs_en & global_output_enable_pin}}), what);
  endtask : check_all

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    for (int i = 0; i < 16; i++) m[i] = RESET_WORD;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check_all("reset state");
    send_w(32'h8000_0000);
    // Random channel settings, then output gating both ways
    for (int it = 0; it < 2; it++) begin
      for (int r = 0; r < 7; r++) begin
        rnd(w);
        send_w((w & ((r == 0) ? 32'h1E01_FFF0 : 32'h0001_FFF0)) | 32'(r));
      end
      rnd(w);
      send_w((w & 32'h0FFF_FFF0) | 32'(REG_FOURTEEN));
      rnd(w);
      send_w((w & 32'h07FF_FFF0) | 32'(REG_FIFTEEN));
      global_output_enable_pin <= w[31];
      repeat (2) @(posedge clk_sys);
      check_all("random config");
      global_output_enable_pin <= ~w[31];
      repeat (2) @(posedge clk_sys);
      check_all("output gating");
    end
    // Two-step zero-delay bring-up for each feedback path
    for (int k = 0; k < 3; k++) begin
      fs = (k == 0) ? FB_CH_FIVE : (k == 1) ? FB_CH_SIX : FB_EXT;
      lsel = (k == 1) ? LD_SEL_LOW : LD_SEL_HIGH;
      fsel <= fs;
      global_output_enable_pin <= 1'b0;
      send_w(32'h9FFF_FFF0);
      check_all("reset word");
      send_w(32'h1000_0000 | (32'(fs) << R0_FBSEL_LSB));
      send_w(32'h0001_0A05);
      send_w(32'h0001_1906);
      send_w(32'h0800_010E | (32'(lsel) << R14_LDSEL_LSB));
      send_w(32'h0480_03CF);
      chk_bit(calibrating, 1'b1, "calibration start");
      chk_bit(lock_pin, lsel == LD_SEL_LOW, "pin while calibrating");
      repeat (CAL + 10) @(posedge clk_sys);
      chk_bit(calibrating, 1'b0, "calibration end");
      chk_bit(lock_pin, lsel == LD_SEL_HIGH, "calibration done");
      check_all("step one");
      global_output_enable_pin <= 1'b1;
      send_w(32'h1800_0000 | (32'(fs) << R0_FBSEL_LSB));
      chk_bit(lock_pin, lsel == LD_SEL_LOW, "back to lock detect");
      send_w(32'h0480_003F);
      chk_bit(calibrating, 1'b0, "no calibration in zero delay");
      check_all("step two");
      fofs <= 0;
      edge_on <= 1'b1;
      repeat (300) @(posedge clk_sys);
      chk_bit(lock_pin, lsel == LD_SEL_HIGH, "locked");
      fofs <= 6;
      repeat (200) @(posedge clk_sys);
      chk_bit(lock_pin, lsel == LD_SEL_LOW, "unlocked");
      edge_on <= 1'b0;
    end
    close_out;
  end

  // Cut a hang short
  initial begin
    #(WATCH_NS);
    err_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    close_out;
  end
endmodule : zero_delay_program_sequencer_tb
`default_nettype wire
